// ==== design/ots_stop_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module ots_stop_ctrl
   import ots_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic forward_limit_input,
   input wire logic reverse_limit_input,
   input wire logic servo_fault,
   input wire logic motor_stopped,
   output logic servo_on,
   output logic short_circuit_brake,
   output logic torque_limit_active,
   output logic [15:0] torque_limit,
   output logic overtravel_display,
   output logic irq
);
   logic fwd_s, rev_s, ot_any, ot_eff;
   logic wr_en;
   logic [31:0] wr_addr;
   logic [31:0] rd_data;
   logic [15:0] wr_idx;
   logic wr_ok;

   // ***********************************************
   // Limit input synchronisers and bus slave.
   // ***********************************************
   ots_sync #(.WIDTH(2)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .din({reverse_limit_input, forward_limit_input}),
      .dout({rev_s, fwd_s})
   );

   ots_ahb_slv u_slv (
      .ref_clk(ref_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .rd_data(rd_data),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_en(wr_en),
      .wr_addr(wr_addr)
   );

   assign wr_idx = ots_idx(wr_addr);
   assign wr_ok = wr_en && ots_ok(wr_addr);

   // ***********************************************
   // Configuration registers.
   // ***********************************************
   logic [7:0] ot_sel_q, ot_sel_d;
   logic [1:0] brake_sel_q, brake_sel_d;
   logic [15:0] tq_lim_q, tq_lim_d;
   logic ctrl_en_q, ctrl_en_d;
   logic [OTS_N_IRQ-1:0] irq_en_q, irq_en_d;
   logic servo_on_q;

   always_comb begin
      ot_sel_d = ot_sel_q;
      brake_sel_d = brake_sel_q;
      tq_lim_d = tq_lim_q;
      ctrl_en_d = ctrl_en_q;
      irq_en_d = irq_en_q;
      // Stop selections are locked while the servo is on.
      if (wr_ok && !servo_on_q) begin
         if (wr_idx == OTS_IDX_OT_SEL && hwdata[7:0] <= OTS_OT_SEL_MAX) begin
            ot_sel_d = hwdata[7:0];
         end
         if (wr_idx == OTS_IDX_BRAKE_SEL) begin
            brake_sel_d = hwdata[1:0];
         end
      end
      if (wr_ok && wr_idx == OTS_IDX_TQ_LIM) begin
         tq_lim_d = hwdata[15:0];
      end
      if (wr_ok && wr_idx == OTS_IDX_CTRL) begin
         ctrl_en_d = hwdata[OTS_CTRL_EN];
      end
      if (wr_ok && wr_idx == OTS_IDX_IRQ_EN) begin
         irq_en_d = hwdata[OTS_N_IRQ-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ot_sel_q <= OTS_OT_SEL_RST;
         brake_sel_q <= OTS_BRAKE_SEL_RST;
         tq_lim_q <= OTS_TQ_LIM_RST;
         ctrl_en_q <= 1'b0;
         irq_en_q <= '0;
      end else begin
         ot_sel_q <= ot_sel_d;
         brake_sel_q <= brake_sel_d;
         tq_lim_q <= tq_lim_d;
         ctrl_en_q <= ctrl_en_d;
         irq_en_q <= irq_en_d;
      end
   end

   // ***********************************************
   // Stop decision.
   // ***********************************************
   // Forward and reverse limits each mark overtravel; the stop does not depend on which one is active.
   assign ot_any = fwd_s || rev_s;
   assign ot_eff = ot_any && (ot_sel_q != OTS_OT_IGNORE);

   ots_state_t state_q, state_d;
   logic brake_q, brake_d;
   logic tqlim_q, tqlim_d;
   logic servo_on_d;
   logic disp_q, disp_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         OTS_OFF: begin
            if (ctrl_en_q && !servo_fault && !ot_eff) begin
               state_d = OTS_ON;
            end
         end
         OTS_ON: begin
            if (servo_fault) begin
               state_d = OTS_BR_STOP;
            end else if (ot_eff && ot_sel_q == OTS_OT_TORQUE) begin
               state_d = OTS_TQ_STOP;
            end else if (ot_eff && ot_sel_q == OTS_OT_BRAKE) begin
               state_d = OTS_BR_STOP;
            end else if (!ctrl_en_q) begin
               state_d = OTS_OFF;
            end
         end
         OTS_TQ_STOP: begin
            if (servo_fault) begin
               state_d = OTS_BR_STOP;
            end else if (!ot_eff) begin
               state_d = ctrl_en_q ? OTS_ON : OTS_OFF;
            end
         end
         OTS_BR_STOP: begin
            if (motor_stopped) begin
               state_d = OTS_HELD;
            end
         end
         OTS_HELD: begin
            if (!ctrl_en_q && !servo_fault && !ot_eff) begin
               state_d = OTS_OFF;
            end
         end
         default: state_d = OTS_OFF;
      endcase
      servo_on_d = (state_d == OTS_ON) || (state_d == OTS_TQ_STOP);
      tqlim_d = (state_d == OTS_TQ_STOP);
      // Braking is only ever applied in the two servo-off stop states.
      case (state_d)
         OTS_BR_STOP: brake_d = (brake_sel_q == OTS_BRK_HOLD) ||
                                (brake_sel_q == OTS_BRK_RELEASE);
         OTS_HELD: brake_d = (brake_sel_q == OTS_BRK_HOLD) ||
                             (brake_sel_q == OTS_BRK_COAST_HOLD);
         default: brake_d = 1'b0;
      endcase
      disp_d = ot_any;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= OTS_OFF;
         servo_on_q <= 1'b0;
         brake_q <= 1'b0;
         tqlim_q <= 1'b0;
         disp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         servo_on_q <= servo_on_d;
         brake_q <= brake_d;
         tqlim_q <= tqlim_d;
         disp_q <= disp_d;
      end
   end

   assign servo_on = servo_on_q;
   assign short_circuit_brake = brake_q;
   assign torque_limit_active = tqlim_q;
   assign torque_limit = tq_lim_q;
   assign overtravel_display = disp_q;

   // ***********************************************
   // Interrupt status.
   // ***********************************************
   logic [OTS_N_IRQ-1:0] irq_st_q, irq_st_d, irq_ev, irq_clr;
   logic fault_prev_q, ot_prev_q;

   always_comb begin
      irq_ev = '0;
      // Limits raise their own event; they never touch the fault bit.
      irq_ev[OTS_IRQ_FAULT] = servo_fault && !fault_prev_q;
      irq_ev[OTS_IRQ_OT] = ot_any && !ot_prev_q;
      irq_ev[OTS_IRQ_HALT] = (state_d == OTS_HELD) && (state_q != OTS_HELD);
      irq_clr = '0;
      if (wr_ok && wr_idx == OTS_IDX_IRQ_CLR) begin
         irq_clr = hwdata[OTS_N_IRQ-1:0];
      end
      // A new event wins over a clear in the same cycle.
      irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_st_q <= '0;
         fault_prev_q <= 1'b0;
         ot_prev_q <= 1'b0;
      end else begin
         irq_st_q <= irq_st_d;
         fault_prev_q <= servo_fault;
         ot_prev_q <= ot_any;
      end
   end

   assign irq = |(irq_st_q & irq_en_q);

   // ***********************************************
   // Read multiplexer.
   // ***********************************************
   always_comb begin
      rd_data = 32'h0000_0000;
      if (ots_ok(haddr)) begin
         case (ots_idx(haddr))
            OTS_IDX_OT_SEL: rd_data[7:0] = ot_sel_q;
            OTS_IDX_BRAKE_SEL: rd_data[1:0] = brake_sel_q;
            OTS_IDX_TQ_LIM: rd_data[15:0] = tq_lim_q;
            OTS_IDX_CTRL: rd_data[OTS_CTRL_EN] = ctrl_en_q;
            OTS_IDX_IRQ_STAT: rd_data[OTS_N_IRQ-1:0] = irq_st_q;
            OTS_IDX_IRQ_EN: rd_data[OTS_N_IRQ-1:0] = irq_en_q;
            OTS_IDX_STATUS: begin
               rd_data[OTS_ST_FWD] = fwd_s;
               rd_data[OTS_ST_REV] = rev_s;
               rd_data[OTS_ST_FAULT] = servo_fault;
               rd_data[OTS_ST_SERVO] = servo_on_q;
               rd_data[OTS_ST_BRAKE] = brake_q;
               rd_data[OTS_ST_TQLIM] = tqlim_q;
               rd_data[OTS_ST_STATE +: 3] = state_q;
            end
            default: rd_data = 32'h0000_0000;
         endcase
      end
   end

   // ***********************************************
   // Assertions.
   // ***********************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_on_fault;
      (state_q == OTS_ON) && servo_fault;
   endsequence

   property p_fault_stop;
      s_on_fault |=> (state_q == OTS_BR_STOP) && !servo_on;
   endproperty
   a_fault_stop: assert property (p_fault_stop)
      else $error("fault did not start a brake stop");

   property p_brake_off;
      short_circuit_brake |-> !servo_on && !torque_limit_active;
   endproperty
   a_brake_off: assert property (p_brake_off)
      else $error("brake applied with servo on");

   property p_tq_stop;
      (state_q == OTS_ON) && !servo_fault && ot_eff &&
      (ot_sel_q == OTS_OT_TORQUE) |=> torque_limit_active && servo_on;
   endproperty
   a_tq_stop: assert property (p_tq_stop)
      else $error("torque stop not entered");

   property p_br_ot;
      (state_q == OTS_ON) && !servo_fault && ot_eff &&
      (ot_sel_q == OTS_OT_BRAKE) |=> state_q == OTS_BR_STOP;
   endproperty
   a_br_ot: assert property (p_br_ot)
      else $error("brake stop on overtravel not entered");

   property p_ignore;
      (state_q == OTS_ON) && !servo_fault && ctrl_en_q &&
      (ot_sel_q == OTS_OT_IGNORE) |=> state_q == OTS_ON;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("limits not ignored at select 2");

   property p_display;
      (fwd_s || rev_s) |=> overtravel_display;
   endproperty
   a_display: assert property (p_display)
      else $error("overtravel display missing");

   property p_sel_lock;
      servo_on_q |=> $stable(ot_sel_q) && $stable(brake_sel_q);
   endproperty
   a_sel_lock: assert property (p_sel_lock)
      else $error("stop selection changed at servo on");

   property p_fault_path;
      $rose(irq_st_q[OTS_IRQ_FAULT]) |-> $past(servo_fault);
   endproperty
   a_fault_path: assert property (p_fault_path)
      else $error("fault flag set without servo fault");

   property p_held_brake;
      (state_q == OTS_HELD) && (brake_sel_q == OTS_BRK_HOLD) |->
         short_circuit_brake;
   endproperty
   a_held_brake: assert property (p_held_brake)
      else $error("hold brake missing after stop");

   property p_sync;
      !$past(rst) && !$past(rst, 2) |-> fwd_s == $past(forward_limit_input, 2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("limit synchroniser latency wrong");
endmodule // ots_stop_ctrl
`default_nettype wire

// ==== design/ots_pkg.sv ====
`default_nettype none
package ots_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] OTS_IDX_BRAKE_SEL = 16'h2001;
   localparam logic [15:0] OTS_IDX_OT_SEL = 16'h2002;
   localparam logic [15:0] OTS_IDX_CTRL = 16'h2010;
   localparam logic [15:0] OTS_IDX_STATUS = 16'h2011;
   localparam logic [15:0] OTS_IDX_IRQ_STAT = 16'h2012;
   localparam logic [15:0] OTS_IDX_IRQ_EN = 16'h2013;
   localparam logic [15:0] OTS_IDX_IRQ_CLR = 16'h2014;
   localparam logic [15:0] OTS_IDX_TQ_LIM = 16'h240B;
   // Reset values and limits.
   localparam logic [7:0] OTS_OT_SEL_RST = 8'h02;
   localparam logic [7:0] OTS_OT_SEL_MAX = 8'h02;
   localparam logic [1:0] OTS_BRAKE_SEL_RST = 2'h0;
   localparam logic [15:0] OTS_TQ_LIM_RST = 16'h0064;
   // Overtravel select codes.
   localparam logic [7:0] OTS_OT_TORQUE = 8'h00;
   localparam logic [7:0] OTS_OT_BRAKE = 8'h01;
   localparam logic [7:0] OTS_OT_IGNORE = 8'h02;
   // Brake method codes.
   localparam logic [1:0] OTS_BRK_HOLD = 2'h0;
   localparam logic [1:0] OTS_BRK_RELEASE = 2'h1;
   localparam logic [1:0] OTS_BRK_COAST = 2'h2;
   localparam logic [1:0] OTS_BRK_COAST_HOLD = 2'h3;
   // Field positions.
   localparam int OTS_CTRL_EN = 0;
   localparam int OTS_IRQ_FAULT = 0;
   localparam int OTS_IRQ_OT = 1;
   localparam int OTS_IRQ_HALT = 2;
   localparam int OTS_N_IRQ = 3;
   localparam int OTS_ST_FWD = 0;
   localparam int OTS_ST_REV = 1;
   localparam int OTS_ST_FAULT = 2;
   localparam int OTS_ST_SERVO = 3;
   localparam int OTS_ST_BRAKE = 4;
   localparam int OTS_ST_TQLIM = 5;
   localparam int OTS_ST_STATE = 8;

   typedef enum logic [2:0] {
      OTS_OFF, OTS_ON, OTS_TQ_STOP, OTS_BR_STOP, OTS_HELD
   } ots_state_t;

   // Word index of a byte address.
   function automatic logic [15:0] ots_idx(input logic [31:0] a);
      return a[17:2];
   endfunction

   // True for an aligned address inside the index space.
   function automatic logic ots_ok(input logic [31:0] a);
      return (a[31:18] == 14'h0000) && (a[1:0] == 2'h0);
   endfunction
endpackage
`default_nettype wire

// ==== design/ots_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ots_sync #(
   parameter int WIDTH = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ***********************************************
   // Two flip-flops per bit; only the second is read.
   // ***********************************************
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
         if (rst) begin
            meta_q[i] <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q[i] <= din[i];
            sync_q[i] <= meta_q[i];
         end
      end
   end
   assign dout = sync_q;
endmodule // ots_sync
`default_nettype wire

// ==== design/ots_ahb_slv.sv ====
`timescale 1ns/1ps
`default_nettype none
module ots_ahb_slv
   import ots_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] rd_data,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic wr_en,
   output logic [31:0] wr_addr
);
   logic acc;
   logic wr_q, wr_d;
   logic [31:0] wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_q, hrdata_d;

   // Zero wait states; read data is captured at the address phase edge.
   assign acc = hsel && htrans[1] && hready;

   always_comb begin
      wr_d = acc && hwrite;
      wr_addr_d = acc ? haddr : wr_addr_q;
      hrdata_d = (acc && !hwrite) ? rd_data : hrdata_q;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_q <= wr_d;
         wr_addr_q <= wr_addr_d;
         hrdata_q <= hrdata_d;
      end
   end

   assign wr_en = wr_q;
   assign wr_addr = wr_addr_q;
   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule // ots_ahb_slv
`default_nettype wire

// ==== verif/ots_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// Limit sensors and power stage
// ***************************************************************
module ots_motor_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fwd_req,
   input wire logic rev_req,
   input wire logic [7:0] stop_cycles,
   input wire logic servo_on,
   output logic forward_limit_input,
   output logic reverse_limit_input,
   output logic motor_stopped
);
   logic [7:0] cnt_q;
   // The sensors switch on a clock edge, unrelated to the bus traffic.
   always_ff @(posedge ref_clk) begin
      forward_limit_input <= fwd_req;
      reverse_limit_input <= rev_req;
      if (rst || servo_on) begin
         cnt_q <= 8'h00;
      end else if (cnt_q != stop_cycles) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // The motor coasts for stop_cycles cycles after torque is removed.
   assign motor_stopped = !servo_on && (cnt_q == stop_cycles);
endmodule // ots_motor_model
`default_nettype wire

// ==== verif/ots_stop_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ots_stop_ctrl_bench
   import ots_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst, hsel, hwrite, fwd_req, rev_req, servo_fault;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] stop_cycles;
   logic hreadyout, hresp, forward_limit_input, reverse_limit_input;
   logic motor_stopped, servo_on, short_circuit_brake, torque_limit_active;
   logic overtravel_display, irq;
   logic [15:0] torque_limit;
   wire logic hready;
   int bad_count = 0;
   int n_tests = 0;
   assign hready = hreadyout;
   always #12.5 ref_clk = ~ref_clk;
   ots_stop_ctrl dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata),
      .forward_limit_input(forward_limit_input),
      .reverse_limit_input(reverse_limit_input),
      .servo_fault(servo_fault), .motor_stopped(motor_stopped),
      .servo_on(servo_on), .short_circuit_brake(short_circuit_brake),
      .torque_limit_active(torque_limit_active),
      .torque_limit(torque_limit), .overtravel_display(overtravel_display),
      .irq(irq));
   ots_motor_model motor (.ref_clk(ref_clk), .rst(rst), .fwd_req(fwd_req),
      .rev_req(rev_req), .stop_cycles(stop_cycles), .servo_on(servo_on),
      .forward_limit_input(forward_limit_input),
      .reverse_limit_input(reverse_limit_input),
      .motor_stopped(motor_stopped));
   // ***************************************************************
   // Tasks
   // ***************************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single AHB transfer; the byte address is four times the index.
   task automatic xfer(input logic wr, input logic [15:0] idx,
                       input logic [31:0] d, output logic [31:0] r);
      int w;
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {14'h0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      w = 0;
      do begin @(posedge ref_clk); w++; end while (hready !== 1'b1 && w < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge ref_clk); w++; end while (hready !== 1'b1 && w < 99);
      r = hrdata;
      chk("hresp", 1'b0, hresp);
      if (w >= 99) bad_count++;
   endtask
   task automatic ot_case(input logic [7:0] sel, input logic [1:0] brk,
                          input logic dir);
      xfer(1'b1, OTS_IDX_OT_SEL, {24'h000000, sel}, v);
      xfer(1'b1, OTS_IDX_BRAKE_SEL, {30'h00000000, brk}, v);
      xfer(1'b1, OTS_IDX_CTRL, 32'h00000001, v);
      repeat (2) @(posedge ref_clk);
      chk("servo_on", 1'b1, servo_on);
      xfer(1'b1, OTS_IDX_OT_SEL, {24'h000000, sel ^ 8'h01}, v);
      xfer(1'b0, OTS_IDX_OT_SEL, 32'h0, v);
      chk("ot_sel locked", {24'h000000, sel}, v);
      fwd_req <= dir;
      rev_req <= !dir;
      repeat (6) @(posedge ref_clk);
      chk("display", 1'b1, overtravel_display);
      chk("servo_on ot", sel != OTS_OT_BRAKE, servo_on);
      chk("clamp", sel == OTS_OT_TORQUE, torque_limit_active);
      if (sel == OTS_OT_TORQUE) chk("clamp value", 16'h1234, torque_limit);
      chk("brake", sel == OTS_OT_BRAKE && brk <= 2'h1, short_circuit_brake);
      xfer(1'b0, OTS_IDX_STATUS, 32'h0, v);
      chk("limit bits", {!dir, dir}, v[1:0]);
      chk("fault bit", 1'b0, v[OTS_ST_FAULT]);
      chk("status flags", {sel == OTS_OT_TORQUE, sel == OTS_OT_BRAKE && brk <= 2'h1,
          sel != OTS_OT_BRAKE}, v[OTS_ST_TQLIM:OTS_ST_SERVO]);
      chk("state", sel == OTS_OT_TORQUE ? OTS_TQ_STOP :
          sel == OTS_OT_BRAKE ? OTS_BR_STOP : OTS_ON, v[10:8]);
      repeat (50) @(posedge ref_clk);
      chk("held brake", sel == OTS_OT_BRAKE && (brk == 2'h0 || brk == 2'h3),
          short_circuit_brake);
      fwd_req <= 1'b0;
      rev_req <= 1'b0;
      xfer(1'b1, OTS_IDX_CTRL, 32'h0, v);
      repeat (6) @(posedge ref_clk);
      chk("off", 2'h0, {servo_on, short_circuit_brake});
      $display("[DONE] overtravel select %0d method %0d", sel, brk);
   endtask
   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      #500000;
      bad_count++;
      complete_run();
   end
   initial begin
      {rst, hsel, hwrite, fwd_req, rev_req, servo_fault} = 6'b100000;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      stop_cycles = 8'h28;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      xfer(1'b0, OTS_IDX_OT_SEL, 32'h0, v);
      chk("ot_sel reset", 32'h00000002, v);
      xfer(1'b0, OTS_IDX_BRAKE_SEL, 32'h0, v);
      chk("brake_sel reset", 32'h00000000, v);
      xfer(1'b0, 16'h3000, 32'h0, v);
      chk("unmapped", 32'h00000000, v);
      xfer(1'b1, OTS_IDX_OT_SEL, 32'h00000003, v);
      xfer(1'b0, OTS_IDX_OT_SEL, 32'h0, v);
      chk("ot_sel range", 32'h00000002, v);
      xfer(1'b1, OTS_IDX_TQ_LIM, 32'h00001234, v);
      $display("[DONE] reset values");
      ot_case(OTS_OT_TORQUE, OTS_BRK_HOLD, 1'b1);
      ot_case(OTS_OT_BRAKE, OTS_BRK_HOLD, 1'b1);
      ot_case(OTS_OT_BRAKE, OTS_BRK_RELEASE, 1'b0);
      ot_case(OTS_OT_BRAKE, OTS_BRK_COAST, 1'b1);
      ot_case(OTS_OT_BRAKE, OTS_BRK_COAST_HOLD, 1'b0);
      ot_case(OTS_OT_IGNORE, OTS_BRK_HOLD, 1'b0);
      xfer(1'b0, OTS_IDX_IRQ_STAT, 32'h0, v);
      chk("irq stat", 32'h00000006, v);
      chk("irq masked", 1'b0, irq);
      xfer(1'b1, OTS_IDX_IRQ_CLR, 32'h00000007, v);
      xfer(1'b0, OTS_IDX_IRQ_STAT, 32'h0, v);
      chk("irq cleared", 32'h00000000, v);
      xfer(1'b1, OTS_IDX_IRQ_EN, 32'h00000001, v);
      xfer(1'b1, OTS_IDX_CTRL, 32'h00000001, v);
      stop_cycles <= 8'h00;
      repeat (2) @(posedge ref_clk);
      servo_fault <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("fault stop", 2'h1, {servo_on, short_circuit_brake});
      chk("irq fault", 1'b1, irq);
      xfer(1'b0, OTS_IDX_STATUS, 32'h0, v);
      chk("status fault", 1'b1, v[OTS_ST_FAULT]);
      xfer(1'b1, OTS_IDX_IRQ_EN, 32'h0, v);
      @(posedge ref_clk);
      chk("irq disabled", 1'b0, irq);
      xfer(1'b1, OTS_IDX_IRQ_EN, 32'h00000001, v);
      xfer(1'b1, OTS_IDX_IRQ_CLR, 32'h00000001, v);
      @(posedge ref_clk);
      chk("irq clear", 1'b0, irq);
      $display("[DONE] servo fault and interrupt");
      complete_run();
   end
endmodule // ots_stop_ctrl_bench
`default_nettype wire
